// *** design/embedded_block_ram.sv ***
/*
  Embedded block RAM of 9216 bits: single port, true dual port, pseudo
  dual port and FIFO modes, mixed port widths, preload and ROM use,
  configured over APB.
  Assumes user fabric drives both ports on i_sys_clk and keeps clock
  enables low around any asynchronous reset.
*/
// How it works
// - Widths x1,x2,x4,x9 in all modes; x18 only pseudo dual and FIFO.
// - Each port of a multi-port mode picks its own width and depth.
// - Bits run LSB to MSB of word 0, then word 1, for every width.
// - Contents may be preloaded after reset from nonvolatile configuration memory.
// - A zero pattern reads no flash and writes zeros to every word.
// - Preload and block writes to use the array as a ROM.
// - Addresses and write data are registered before reaching the array.
// - Read path has an optional output register adding one clock.
// - In FIFO mode a read pointer reset replays data already written.
// - Output latch reset acts synchronously or asynchronously by option.
// - Each port's local reset clears only its own output latch.
// - Global reset clears both latches and always acts asynchronously.
`timescale 1ns/1ps
`default_nettype none
module embedded_block_ram (
  // Clock and global reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Port A
  input  wire logic        i_a_ce,
  input  wire logic        i_a_we,
  input  wire logic [12:0] i_a_addr,
  input  wire logic [17:0] i_a_wdata,
  input  wire logic        i_port_a_latch_reset,
  output logic      [17:0] o_a_rdata,
  // Port B
  input  wire logic        i_b_ce,
  input  wire logic        i_b_we,
  input  wire logic [12:0] i_b_addr,
  input  wire logic [17:0] i_b_wdata,
  input  wire logic        i_port_b_latch_reset,
  output logic      [17:0] o_b_rdata,
  // FIFO control and flags
  input  wire logic        i_read_pointer_reset,
  output logic             o_fifo_empty,
  output logic             o_fifo_full,
  // Preload source
  input  wire logic [1:0]  i_init_mode,
  input  wire logic [17:0] i_nv_data,
  output logic             o_nv_rd,
  output logic      [8:0]  o_nv_addr,
  output logic             o_preload_done
);
  // ==========================================================
  // Declarations
  logic        mem_q [ram_pkg::MEM_BITS];
  logic [11:0] ctrl_q;
  logic [1:0]  mode;
  logic [2:0]  wa;
  logic [2:0]  wb;
  logic [4:0]  wa_n;
  logic [4:0]  wb_n;
  logic [13:0] cap;
  logic        rom;
  logic        is_fifo;
  logic        ld_wr;
  logic [8:0]  ld_idx;
  logic [17:0] ld_data;
  logic [13:0] ld_off;
  logic        a_wr;
  logic        b_wr;
  logic        push;
  logic        pop;
  logic [13:0] a_off;
  logic [13:0] b_off;
  logic [13:0] wr_ptr_q;
  logic [13:0] wr_ptr_d;
  logic [13:0] rd_ptr_q;
  logic [13:0] rd_ptr_d;
  logic [13:0] cnt_q;
  logic [13:0] cnt_d;
  logic        setup;
  logic        access;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        ctrl_ok;
  logic        ctrl_wr;
  logic [31:0] stat_word;

  ram_port_if pa ();
  ram_port_if pb ();

  // ==========================================================
  // Configuration fields
  assign mode    = ctrl_q[ram_pkg::CTRL_MODE +: 2];
  assign wa      = ctrl_q[ram_pkg::CTRL_WA +: 3];
  assign wb      = ctrl_q[ram_pkg::CTRL_WB +: 3];
  assign rom     = ctrl_q[ram_pkg::CTRL_ROM];
  assign is_fifo = (mode == ram_pkg::MODE_FIFO);
  assign wa_n    = ram_pkg::width_of(wa);
  assign wb_n    = ram_pkg::width_of(wb);
  assign cap     = ram_pkg::cap_of(wa);

  // ==========================================================
  // Preload sequencer
  ram_preload u_preload (
    .i_sys_clk   (i_sys_clk),
    .i_arst_n    (i_arst_n),
    .i_init_mode (i_init_mode),
    .i_nv_data   (i_nv_data),
    .o_nv_rd     (o_nv_rd),
    .o_nv_addr   (o_nv_addr),
    .o_wr_en     (ld_wr),
    .o_wr_idx    (ld_idx),
    .o_wr_data   (ld_data),
    .o_done      (o_preload_done)
  );

  assign ld_off = {5'h0, ld_idx} * 14'(ram_pkg::WORD_BITS);

  // ==========================================================
  // Ports; port B only listens outside single port mode
  ram_port u_port_a (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_en      (o_preload_done),
    .i_ce      (i_a_ce),
    .i_we      (i_a_we),
    .i_addr    (i_a_addr),
    .i_wdata   (i_a_wdata),
    .i_outreg  (ctrl_q[ram_pkg::CTRL_OREGA]),
    .i_async   (ctrl_q[ram_pkg::CTRL_ASYNC]),
    .i_lrst    (i_port_a_latch_reset),
    .o_rdata   (o_a_rdata),
    .p         (pa)
  );

  ram_port u_port_b (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_en      (o_preload_done && mode != ram_pkg::MODE_SP),
    .i_ce      (i_b_ce),
    .i_we      (i_b_we),
    .i_addr    (i_b_addr),
    .i_wdata   (i_b_wdata),
    .i_outreg  (ctrl_q[ram_pkg::CTRL_OREGB]),
    .i_async   (ctrl_q[ram_pkg::CTRL_ASYNC]),
    .i_lrst    (i_port_b_latch_reset),
    .o_rdata   (o_b_rdata),
    .p         (pb)
  );

  // ==========================================================
  // Write decisions; ROM mode blocks every user write
  assign push = is_fifo && pa.ce && pa.we && !rom && !o_fifo_full;
  assign pop  = is_fifo && pb.ce && !o_fifo_empty;
  assign a_wr = pa.ce && pa.we && !rom && (!is_fifo || push);
  assign b_wr = pb.ce && pb.we && !rom && (mode == ram_pkg::MODE_TDP);

  // Bit offsets: word k of width w starts at bit k*w in every port
  assign a_off = is_fifo ? wr_ptr_q : ram_pkg::bit_off(wa, pa.addr);
  assign b_off = is_fifo ? rd_ptr_q : ram_pkg::bit_off(wb, pb.addr);

  // ==========================================================
  // Array writes; of two ports writing one bit, port B wins at equal offsets, otherwise the write from the higher word bit wins
  always_ff @(posedge i_sys_clk) begin
    for (int i = 0; i < ram_pkg::WORD_BITS; i++) begin
      if (ld_wr) begin
        mem_q[int'(ld_off) + i] <= ld_data[i];
      end
      if (a_wr && i < int'(wa_n) && int'(a_off) + i < ram_pkg::MEM_BITS) begin
        mem_q[int'(a_off) + i] <= pa.wdata[i];
      end
      if (b_wr && i < int'(wb_n) && int'(b_off) + i < ram_pkg::MEM_BITS) begin
        mem_q[int'(b_off) + i] <= pb.wdata[i];
      end
    end
  end

  // Array reads from the registered address; bits above the width read zero
  always_comb begin
    pa.rd_word = 18'h0;
    pb.rd_word = 18'h0;
    for (int i = 0; i < ram_pkg::WORD_BITS; i++) begin
      if (i < int'(wa_n) && int'(a_off) + i < ram_pkg::MEM_BITS) begin
        pa.rd_word[i] = mem_q[int'(a_off) + i];
      end
      if (i < int'(wb_n) && int'(b_off) + i < ram_pkg::MEM_BITS) begin
        pb.rd_word[i] = mem_q[int'(b_off) + i];
      end
    end
  end

  // ==========================================================
  // FIFO pointers in bits, so mixed widths share one count
  function automatic logic [13:0] wrap(input logic [13:0] ptr, input logic [4:0] step,
                                       input logic [13:0] lim);
    logic [14:0] nxt;
    nxt = {1'b0, ptr} + {10'h0, step};
    wrap = (nxt >= {1'b0, lim}) ? 14'(nxt - {1'b0, lim}) : nxt[13:0];
  endfunction

  // Retransmit only replays from bit zero; data wrapped past the end is lost
  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    cnt_d    = cnt_q;
    if (ctrl_wr) begin
      wr_ptr_d = 14'h0;
      rd_ptr_d = 14'h0;
      cnt_d    = 14'h0;
    end else if (is_fifo) begin
      if (push) begin
        wr_ptr_d = wrap(wr_ptr_q, wa_n, cap);
        cnt_d    = cnt_q + {9'h0, wa_n};
      end
      if (i_read_pointer_reset) begin
        rd_ptr_d = 14'h0;
        cnt_d    = wr_ptr_d;
      end else if (pop) begin
        rd_ptr_d = wrap(rd_ptr_q, wb_n, cap);
        cnt_d    = cnt_d - {9'h0, wb_n};
      end
    end
  end

  // Pointer state and flags, flags always match the stored count
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr_q     <= 14'h0;
      rd_ptr_q     <= 14'h0;
      cnt_q        <= 14'h0;
      o_fifo_empty <= 1'b1;
      o_fifo_full  <= 1'b0;
    end else begin
      wr_ptr_q     <= wr_ptr_d;
      rd_ptr_q     <= rd_ptr_d;
      cnt_q        <= cnt_d;
      o_fifo_empty <= cnt_d < {9'h0, wb_n};
      o_fifo_full  <= ({1'b0, cnt_d} + {10'h0, wa_n}) > {1'b0, cap};
    end
  end

  // ==========================================================
  // APB decode; zero wait states, answer prepared in the setup cycle
  assign setup    = i_psel && !i_penable;
  assign access   = i_psel && i_penable && o_pready;
  assign hit_ctrl = (i_paddr == ram_pkg::ADDR_CTRL);
  assign hit_stat = (i_paddr == ram_pkg::ADDR_STATUS);
  assign ctrl_wr  = access && i_pwrite && hit_ctrl && ctrl_ok;
  assign stat_word = {15'h0, cnt_q, o_fifo_full, o_fifo_empty, o_preload_done};

  // Width x18 is refused in single and true dual port modes
  always_comb begin
    ctrl_ok = (i_pwdata[ram_pkg::CTRL_WA +: 3] <= ram_pkg::W18) &&
              (i_pwdata[ram_pkg::CTRL_WB +: 3] <= ram_pkg::W18);
    if (i_pwdata[ram_pkg::CTRL_MODE +: 2] == ram_pkg::MODE_SP ||
        i_pwdata[ram_pkg::CTRL_MODE +: 2] == ram_pkg::MODE_TDP) begin
      if (i_pwdata[ram_pkg::CTRL_WA +: 3] == ram_pkg::W18 ||
          i_pwdata[ram_pkg::CTRL_WB +: 3] == ram_pkg::W18) begin
        ctrl_ok = 1'b0;
      end
    end
  end

  // Read data and error flag, captured when the setup phase is seen
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_prdata  <= 32'h0;
      o_pslverr <= 1'b0;
      o_pready  <= 1'b0;
    end else begin
      o_pready <= 1'b1;
      if (setup) begin
        o_prdata  <= hit_ctrl ? {20'h0, ctrl_q} : (hit_stat ? stat_word : 32'h0);
        o_pslverr <= !(hit_ctrl || hit_stat) || (i_pwrite && hit_ctrl && !ctrl_ok);
      end
    end
  end

  // Control register, written only with a legal combination
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= ram_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= i_pwdata[11:0];
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  property p_cfg18;
    (mode == ram_pkg::MODE_SP || mode == ram_pkg::MODE_TDP) |-> wa != ram_pkg::W18 && wb != ram_pkg::W18;
  endproperty
  a_cfg18: assert property (p_cfg18) else $error("x18 held in a true port mode");

  property p_reject;
    i_psel && i_penable && i_pwrite && hit_ctrl && !ctrl_ok |-> o_pslverr ##1 $stable(ctrl_q);
  endproperty
  a_reject: assert property (p_reject) else $error("illegal setting was taken");

  property p_rom;
    rom |-> !a_wr && !b_wr;
  endproperty
  a_rom: assert property (p_rom) else $error("write reached array in ROM use");

  property p_preload;
    !o_preload_done |-> !pa.ce && !pb.ce;
  endproperty
  a_preload: assert property (p_preload) else $error("port active during preload");

  sequence s_replay;
    is_fifo && i_read_pointer_reset && !ctrl_wr;
  endsequence
  property p_replay;
    s_replay |=> rd_ptr_q == 14'h0 && cnt_q == wr_ptr_q;
  endproperty
  a_replay: assert property (p_replay) else $error("read pointer reset did not replay");

  property p_tdp;
    mode == ram_pkg::MODE_TDP && pa.ce && pa.we && pb.ce && pb.we && !rom |-> a_wr && b_wr;
  endproperty
  a_tdp: assert property (p_tdp) else $error("dual port write dropped");

  property p_pop_empty;
    o_fifo_empty |-> !pop ##1 (o_fifo_empty || cnt_q >= {9'h0, wb_n});
  endproperty
  a_pop_empty: assert property (p_pop_empty) else $error("pop from empty FIFO");
endmodule // embedded_block_ram
`default_nettype wire

// *** include/ram_pkg.sv ***
/*
  Constants, codes and helpers shared by the block RAM, its ports and
  its preload sequencer.
  Assumes a 32-bit APB register bus and an 18-bit preload word source.
*/
package ram_pkg;
  // ==========================================================
  // Array geometry
  localparam int          MEM_BITS  = 9216;
  localparam int          WORD_BITS = 18;
  localparam logic [8:0]  NV_LAST   = 9'h1ff;
  localparam logic [13:0] CAP_NARROW = 14'h2000;
  localparam logic [13:0] CAP_WIDE   = 14'h2400;
  // ==========================================================
  // Memory modes and port width codes
  localparam logic [1:0] MODE_SP   = 2'h0;
  localparam logic [1:0] MODE_TDP  = 2'h1;
  localparam logic [1:0] MODE_PDP  = 2'h2;
  localparam logic [1:0] MODE_FIFO = 2'h3;
  localparam logic [2:0] W1  = 3'h0;
  localparam logic [2:0] W2  = 3'h1;
  localparam logic [2:0] W4  = 3'h2;
  localparam logic [2:0] W9  = 3'h3;
  localparam logic [2:0] W18 = 3'h4;
  // Preload sources
  localparam logic [1:0] INIT_NONE = 2'h0;
  localparam logic [1:0] INIT_ZERO = 2'h1;
  localparam logic [1:0] INIT_NV   = 2'h2;
  // ==========================================================
  // Register map and fields
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] CTRL_RESET  = 12'h000;
  localparam int CTRL_MODE  = 0;
  localparam int CTRL_WA    = 2;
  localparam int CTRL_WB    = 5;
  localparam int CTRL_OREGA = 8;
  localparam int CTRL_OREGB = 9;
  localparam int CTRL_ASYNC = 10;
  localparam int CTRL_ROM   = 11;

  // Data width of a port for its width code
  function automatic logic [4:0] width_of(input logic [2:0] wc);
    case (wc)
      W2:      width_of = 5'h2;
      W4:      width_of = 5'h4;
      W9:      width_of = 5'h9;
      W18:     width_of = 5'h12;
      default: width_of = 5'h1;
    endcase
  endfunction

  // Usable bits of the array for a port width
  function automatic logic [13:0] cap_of(input logic [2:0] wc);
    cap_of = (wc == W9 || wc == W18) ? CAP_WIDE : CAP_NARROW;
  endfunction

  // First array bit of a word, address folded to the port depth
  function automatic logic [13:0] bit_off(input logic [2:0] wc, input logic [12:0] a);
    case (wc)
      W1:      bit_off = {1'b0, a};
      W2:      bit_off = {1'b0, a[11:0], 1'b0};
      W4:      bit_off = {1'b0, a[10:0], 2'h0};
      W9:      bit_off = {4'h0, a[9:0]} * 14'h9;
      W18:     bit_off = {5'h0, a[8:0]} * 14'h12;
      default: bit_off = 14'h0;
    endcase
  endfunction
endpackage

// *** include/ram_port_if.sv ***
/*
  Registered request of one RAM port and the word read back for it.
  Assumes the port module drives the request and the core the read word.
*/
`timescale 1ns/1ps
`default_nettype none
interface ram_port_if;
  logic        ce;
  logic        we;
  logic [12:0] addr;
  logic [17:0] wdata;
  logic [17:0] rd_word;
  modport port (output ce, we, addr, wdata, input rd_word);
  modport core (input ce, we, addr, wdata, output rd_word);
endinterface
`default_nettype wire

// *** design/ram_port.sv ***
/*
  One RAM port: input registers, read data latch, optional output stage.
  Assumes i_sys_clk is the only clock and the core answers rd_word combinationally.
*/
`timescale 1ns/1ps
`default_nettype none
module ram_port (
  // Clock and global reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  // User request
  input  wire logic        i_en,
  input  wire logic        i_ce,
  input  wire logic        i_we,
  input  wire logic [12:0] i_addr,
  input  wire logic [17:0] i_wdata,
  // Options and local latch reset
  input  wire logic        i_outreg,
  input  wire logic        i_async,
  input  wire logic        i_lrst,
  // Read data and core side
  output logic      [17:0] o_rdata,
  ram_port_if.port         p
);
  logic [17:0] stage_q;
  logic [17:0] out_q;
  logic        lat_rst_n;

  // ==========================================================
  // Input registers, cleared only by the global reset
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      p.ce    <= 1'b0;
      p.we    <= 1'b0;
      p.addr  <= 13'h0;
      p.wdata <= 18'h0;
    end else begin
      p.ce    <= i_ce & i_en;
      p.we    <= i_we;
      p.addr  <= i_addr;
      p.wdata <= i_wdata;
    end
  end

  // Local reset joins the global one only in asynchronous mode
  assign lat_rst_n = i_arst_n & ~(i_async & i_lrst);

  // Latch and output stage; the user keeps enables low around an async reset
  always_ff @(posedge i_sys_clk or negedge lat_rst_n) begin
    if (!lat_rst_n) begin
      stage_q <= 18'h0;
      out_q   <= 18'h0;
    end else if (i_lrst) begin
      stage_q <= 18'h0;
      out_q   <= 18'h0;
    end else begin
      if (p.ce) begin
        stage_q <= p.rd_word;
      end
      if (i_outreg) begin
        out_q <= stage_q;
      end else if (p.ce) begin
        out_q <= p.rd_word;
      end
    end
  end

  assign o_rdata = out_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_read;
    p.ce && !i_lrst;
  endsequence
  property p_bypass;
    s_read and !i_outreg |=> out_q == $past(p.rd_word);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass read latency wrong");
  property p_outreg;
    (s_read and i_outreg) ##1 (i_outreg && !i_lrst) |=> out_q == $past(p.rd_word, 2);
  endproperty
  a_outreg: assert property (p_outreg) else $error("registered read latency wrong");
  property p_lrst;
    i_lrst |=> out_q == 18'h0 && stage_q == 18'h0;
  endproperty
  a_lrst: assert property (p_lrst) else $error("local reset did not clear latch");
endmodule // ram_port
`default_nettype wire

// *** design/ram_preload.sv ***
/*
  Preload sequencer: fills the array with zeros or with words fetched
  from nonvolatile configuration memory after reset.
  Assumes the memory answers i_nv_data in the cycle after o_nv_rd.
*/
`timescale 1ns/1ps
`default_nettype none
module ram_preload (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  // Preload source
  input  wire logic [1:0]  i_init_mode,
  input  wire logic [17:0] i_nv_data,
  output logic             o_nv_rd,
  output logic      [8:0]  o_nv_addr,
  // Array write and completion
  output logic             o_wr_en,
  output logic      [8:0]  o_wr_idx,
  output logic      [17:0] o_wr_data,
  output logic             o_done
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_REQ  = 4'h2,
    ST_TAKE = 4'h4,
    ST_DONE = 4'h8
  } ld_state_t;
  ld_state_t  state_q;
  logic [1:0] mode_q;

  // ==========================================================
  // Strap is caught on the first edge after release, never by the reset
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q   <= ST_IDLE;
      mode_q    <= ram_pkg::INIT_NONE;
      o_nv_rd   <= 1'b0;
      o_nv_addr <= 9'h0;
      o_wr_en   <= 1'b0;
      o_wr_idx  <= 9'h0;
      o_wr_data <= 18'h0;
      o_done    <= 1'b0;
    end else begin
      o_wr_en <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          mode_q    <= i_init_mode;
          o_nv_addr <= 9'h0;
          o_nv_rd   <= (i_init_mode == ram_pkg::INIT_NV);
          state_q   <= (i_init_mode == ram_pkg::INIT_NONE) ? ST_DONE : ST_REQ;
          o_done    <= (i_init_mode == ram_pkg::INIT_NONE);
        end
        ST_REQ: begin
          o_nv_rd <= 1'b0;
          state_q <= ST_TAKE;
        end
        ST_TAKE: begin
          // A zero pattern never touches the flash, so it costs no stored bits
          o_wr_data <= (mode_q == ram_pkg::INIT_ZERO) ? 18'h0 : i_nv_data;
          o_wr_en   <= 1'b1;
          o_wr_idx  <= o_nv_addr;
          if (o_nv_addr == ram_pkg::NV_LAST) begin
            state_q <= ST_DONE;
            o_done  <= 1'b1;
          end else begin
            o_nv_addr <= o_nv_addr + 9'h1;
            o_nv_rd   <= (mode_q == ram_pkg::INIT_NV);
            state_q   <= ST_REQ;
          end
        end
        ST_DONE: begin
          o_done <= 1'b1;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  property p_zero;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    (mode_q == ram_pkg::INIT_ZERO && state_q != ST_IDLE) |-> !o_nv_rd && (!o_wr_en || o_wr_data == 18'h0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero preload read the flash");
endmodule // ram_preload
`default_nettype wire

// *** tb/nv_source.sv ***
/*
  Nonvolatile preload word source facing the block RAM.
  Assumes one read strobe per word and data wanted the next cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module nv_source (
  // Clock and read request
  input  wire logic        i_sys_clk,
  input  wire logic        i_rd,
  input  wire logic [8:0]  i_addr,
  // Word returned
  output logic      [17:0] o_data
);
  // Word k holds its own index, so misplaced words show up
  function automatic logic [17:0] pat(input logic [8:0] k);
    pat = {k, ~k};
  endfunction
  // Answer one cycle after the strobe, else toggle so stale data is never reused
  initial o_data = 18'h2aaaa;
  always @(posedge i_sys_clk) begin
    o_data <= i_rd ? pat(i_addr) : ~o_data;
  end
endmodule // nv_source
`default_nettype wire

// *** tb/tb_embedded_block_ram.sv ***
/*
  Self-checking bench: preload, widths, x9 mapping, output stage, ROM, latch reset.
  Assumes zero-wait APB and reads answered two or three edges after ce.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_embedded_block_ram;
  // ==========================================================
  // Signals
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, done, nv_rd;
  logic a_ce, a_we, b_ce, b_we, lrst_a, lrst_b, rp_rst, empty, full;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [12:0] a_addr, b_addr;
  logic [17:0] a_wd, b_wd, a_rd, b_rd, nv_data;
  logic [1:0] init_mode;
  logic [8:0] nv_addr;
  logic [2:0] hist_a = 3'h0, hist_b = 3'h0;
  logic apb_rd = 1'b0;
  logic [17:0] q_ram[$];
  logic [32:0] q_apb[$];
  int n_fail = 0, n_tests = 0, lat = 1, cyc = 0;
  embedded_block_ram embedded_block_ram_inst (.i_sys_clk(clk), .i_arst_n(rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_a_ce(a_ce), .i_a_we(a_we), .i_a_addr(a_addr), .i_a_wdata(a_wd),
    .i_port_a_latch_reset(lrst_a), .o_a_rdata(a_rd), .i_b_ce(b_ce), .i_b_we(b_we),
    .i_b_addr(b_addr), .i_b_wdata(b_wd), .i_port_b_latch_reset(lrst_b),
    .o_b_rdata(b_rd), .i_read_pointer_reset(rp_rst), .o_fifo_empty(empty),
    .o_fifo_full(full), .i_init_mode(init_mode), .i_nv_data(nv_data),
    .o_nv_rd(nv_rd), .o_nv_addr(nv_addr), .o_preload_done(done));
  nv_source nv_source_inst (.i_sys_clk(clk), .i_rd(nv_rd), .i_addr(nv_addr),
    .o_data(nv_data));
  // ==========================================================
  // Clock, stimulus helpers and compares
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // x9 word k sits in bits 9k..9k+8, so it is half of preload word k/2
  function automatic logic [17:0] exp9(input logic [12:0] a);
    logic [17:0] p;
    p = nv_source_inst.pat(a[9:1]);
    exp9 = a[0] ? {9'h0, p[17:9]} : {9'h0, p[8:0]};
  endfunction
  task automatic fail_msg(input logic [32:0] e, input logic [32:0] g);
    n_fail++;
    $display("mismatch at %0t exp %h got %h", $time, e, g);
  endtask
  task automatic cmp_ram(input logic [17:0] g);
    logic [17:0] e;
    n_tests++;
    e = (q_ram.size() != 0) ? q_ram.pop_front() : 18'hx;
    if (e !== g) fail_msg({15'h0, e}, {15'h0, g});
  endtask
  task automatic cmp_apb(input logic [32:0] g);
    logic [32:0] e;
    n_tests++;
    e = (q_apb.size() != 0) ? q_apb.pop_front() : 33'hx;
    if (e !== g) fail_msg(e, g);
  endtask
  // Setup, then access held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    if (!w) q_apb.push_back(e);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask
  // One port request per cycle; the other port's ce drops so it reads nothing
  task automatic prt(input logic b, input logic w, input logic [12:0] a,
                     input logic [17:0] d, input logic [17:0] e);
    if (!w) q_ram.push_back(e);
    {a_ce, b_ce} <= {~b, b};
    if (b) {b_we, b_addr, b_wd} <= {w, a, d};
    else {a_we, a_addr, a_wd} <= {w, a, d};
    @(posedge clk);
  endtask
  task automatic idle();
    {a_ce, b_ce} <= 2'b00;
    repeat (4) @(posedge clk);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // Monitor: reads retire lat+1 edges after ce, checked mid-cycle
  always @(posedge clk) begin
    hist_a <= {hist_a[1:0], a_ce & ~a_we};
    hist_b <= {hist_b[1:0], b_ce & ~b_we};
    apb_rd <= psel & penable & pready & ~pwrite;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      test_done();
    end
  end
  always @(negedge clk) begin
    if (hist_a[lat]) cmp_ram(a_rd);
    if (hist_b[lat]) cmp_ram(b_rd);
    if (apb_rd) cmp_apb({pslverr, prdata});
  end
  // ==========================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, a_ce, a_we, b_ce, b_we, lrst_a, lrst_b, rp_rst} = 10'h0;
    {paddr, pwdata, a_addr, b_addr, a_wd, b_wd} = 106'h0;
    init_mode = ram_pkg::INIT_NV;
    rnd = 32'h97fc816d;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    while (done !== 1'b1) @(posedge clk);
    apb(1'b0, ram_pkg::ADDR_STATUS, 32'h0, 33'h3);
    apb(1'b0, 12'hffc, 32'h0, 33'h100000000);
    apb(1'b1, ram_pkg::ADDR_CTRL, 32'h91, 33'h0);
    apb(1'b0, ram_pkg::ADDR_CTRL, 32'h0, 33'h0);
    $display("test config done");
    // Dual port x9 on both sides, bypass then output register
    for (int o = 0; o < 2; o++) begin
      apb(1'b1, ram_pkg::ADDR_CTRL, 32'h6d | (o << 8) | (o << 9), 33'h0);
      lat = o + 1;
      repeat (8) begin
        rnd = lfsr(rnd);
        prt(rnd[10], 1'b0, {3'h0, rnd[9:0]}, 18'h0, exp9({3'h0, rnd[9:0]}));
      end
      idle();
    end
    lat = 1;
    $display("test preload done");
    // Write blocked in ROM use, then allowed and seen from the other port
    apb(1'b1, ram_pkg::ADDR_CTRL, 32'h86d, 33'h0);
    prt(1'b0, 1'b1, 13'h4, 18'h155, 18'h0);
    idle();
    prt(1'b0, 1'b0, 13'h4, 18'h0, exp9(13'h4));
    idle();
    apb(1'b1, ram_pkg::ADDR_CTRL, 32'h6d, 33'h0);
    prt(1'b0, 1'b1, 13'h4, 18'h155, 18'h0);
    idle();
    prt(1'b1, 1'b0, 13'h4, 18'h0, 18'h155);
    prt(1'b0, 1'b0, 13'h4, 18'h0, 18'h155);
    idle();
    $display("test write done");
    // Synchronous local reset clears port A only, then asynchronous local reset clears port B
    lrst_a <= 1'b1;
    @(posedge clk);
    lrst_a <= 1'b0;
    @(negedge clk);
    q_ram.push_back(18'h0);
    cmp_ram(a_rd);
    q_ram.push_back(18'h155);
    cmp_ram(b_rd);
    @(posedge clk);
    apb(1'b1, ram_pkg::ADDR_CTRL, 32'h46d, 33'h0);
    lrst_b <= 1'b1;
    @(negedge clk);
    q_ram.push_back(18'h0);
    cmp_ram(b_rd);
    @(posedge clk);
    lrst_b <= 1'b0;
    idle();
    $display("test latch reset done");
    // FIFO replay
    apb(1'b1, ram_pkg::ADDR_CTRL, 32'h6f, 33'h0);
    prt(1'b0, 1'b1, 13'h0, 18'h1a5, 18'h0);
    prt(1'b1, 1'b0, 13'h0, 18'h0, 18'h1a5);
    idle();
    rp_rst <= 1'b1;
    @(posedge clk);
    rp_rst <= 1'b0;
    prt(1'b1, 1'b0, 13'h0, 18'h0, 18'h1a5);
    idle();
    apb(1'b0, ram_pkg::ADDR_STATUS, 32'h0, 33'h3);
    $display("test fifo done");
    // Global reset, zero preload
    init_mode <= ram_pkg::INIT_ZERO;
    rst_n <= 1'b0;
    @(negedge clk);
    q_ram.push_back(18'h0);
    cmp_ram(b_rd);
    @(posedge clk);
    rst_n <= 1'b1;
    while (done !== 1'b1) @(posedge clk);
    prt(1'b0, 1'b0, 13'h24, 18'h0, 18'h0);
    idle();
    $display("test reset done");
    test_done();
  end
endmodule // tb_embedded_block_ram
`default_nettype wire
